// ==== core/hdlc_controller.v ====
// HDLC packet controller for one framer: register port, two 256-byte FIFOs, bit engines.
// Assumes the framer supplies a per-bit tick with slot, bit and overhead position, on MCLK.
`timescale 1ns/1ns
`default_nettype none
`include "hdlc_regs.vh"
module hdlc_controller #(
	parameter [2:0] FRAMER = 3'h1
) (
	input wire MCLK,
	input wire RST,
	input wire CE,
	input wire [15:0] ADDR,
	input wire [7:0] WDATA,
	input wire WR,
	input wire RD,
	output reg [7:0] RDATA,
	input wire LINE_TICK,
	input wire [4:0] SLOT,
	input wire [2:0] BITPOS,
	input wire SA_BIT,
	input wire [2:0] SA_NUM,
	input wire FDL_BIT,
	input wire RX_LINE,
	output reg TX_LINE,
	output reg IRQ_N
);
	function [15:0] crc_step;
		input [15:0] c;
		input b;
		begin
			crc_step = {1'b0, c[15:1]} ^ ((c[0] ^ b) ? `CRC_POLY : 16'h0000);
		end
	endfunction

	function [7:0] rev8;
		input [7:0] v;
		integer i;
		begin
			for (i = 0; i < 8; i = i + 1)
				rev8[i] = v[7 - i];
		end
	endfunction

	wire [15:0] base = {13'h0000, FRAMER - 3'h1} << `FRAMER_SHIFT;
	wire [15:0] la = ADDR - base;
	wire wr = CE & WR;
	wire rd = CE & RD;

	reg [1:0] rx_map;
	reg [1:0] tx_map;
	reg [7:0] rx_sup;
	reg [7:0] tx_sup;
	reg [31:0] rx_sel;
	reg [31:0] tx_sel;
	reg [7:0] rx_misc;
	reg [7:0] tx_misc;
	reg [7:0] rx_lvl;
	reg [7:0] tx_lvl;
	reg [7:0] rx_ie;
	reg [7:0] tx_ie;
	reg [7:0] rx_lat;
	reg [7:0] tx_lat;
	reg [7:0] rx_pend;
	reg [7:0] tx_pend;
	reg tx_abort_req;

	// A tick is used only where the mapping selects this slot, bit or overhead position.
	wire rx_use = (rx_map == `MAP_SLOT) ? (rx_sel[SLOT] & ~rx_sup[BITPOS]) :
		(rx_map == `MAP_SA) ? (SA_BIT & ~rx_sup[SA_NUM]) :
		(rx_map == `MAP_FDL) ? FDL_BIT : 1'b0;
	wire tx_use = (tx_map == `MAP_SLOT) ? (tx_sel[SLOT] & ~tx_sup[BITPOS]) :
		(tx_map == `MAP_SA) ? (SA_BIT & ~tx_sup[SA_NUM]) :
		(tx_map == `MAP_FDL) ? FDL_BIT : 1'b0;
	wire rx_go = CE & LINE_TICK & rx_use & rx_misc[`CTL_EN];
	wire tx_tick = CE & LINE_TICK & tx_use;
	wire tx_go = tx_tick & tx_misc[`CTL_EN];

	// Receive FIFO: each entry is a tag and a byte.
	reg [9:0] rx_mem [0:255];
	reg [7:0] rx_wp;
	reg [7:0] rx_rp;
	reg [8:0] rx_cnt;
	wire rx_full = (rx_cnt == `FIFO_DEPTH);
	wire rx_empty = (rx_cnt == 9'h000);
	wire rx_room = ((`FIFO_DEPTH - rx_cnt) >= `RX_ROOM);
	wire rx_pop = rd & (la == `ADR_RX_FD2) & ~rx_empty;
	wire rx_invalid = rd & (la == `ADR_RX_FD2) & rx_empty;

	// Transmit FIFO: each entry is an end-of-packet mark and a byte.
	reg [8:0] tx_mem [0:255];
	reg [7:0] tx_wp;
	reg [7:0] tx_rp;
	reg [8:0] tx_cnt;
	wire tx_full = (tx_cnt == `FIFO_DEPTH);
	wire tx_wr = wr & ((la == `ADR_TX_FD1) | (la == `ADR_TX_FD2));
	wire tx_push = tx_wr & ~tx_full;
	wire tx_ovf = tx_wr & tx_full;
	wire [8:0] tx_free = `FIFO_DEPTH - tx_cnt;
	wire [7:0] tx_space = tx_free[8] ? 8'hff : tx_free[7:0];

	// Receive bit engine state.
	reg [2:0] ones;
	reg [30:0] hist;
	reg [5:0] rt;
	reg [2:0] ph;
	reg [15:0] rcrc;
	reg in_fr;
	reg first;
	reg req_v;
	reg req_st;
	reg [9:0] req_d;
	reg rx_drop;
	reg rx_owe;

	wire rx_take = rx_go & in_fr & (RX_LINE ? (ones < `ONES_FLAG) : (ones < `ONES_STUFF));
	wire rx_flag = rx_go & ~RX_LINE & (ones == `ONES_FLAG);
	wire rx_abt = rx_go & RX_LINE & (ones == `ONES_FLAG);

	always @(posedge MCLK)
	begin
		if (RST)
		begin
			ones <= 3'h0;
			hist <= 31'h0000_0000;
			rt <= 6'h00;
			ph <= 3'h0;
			rcrc <= `CRC_INIT;
			in_fr <= 1'b0;
			first <= 1'b1;
			req_v <= 1'b0;
			req_st <= 1'b0;
			req_d <= 10'h000;
		end
		else if (CE)
		begin
			req_v <= 1'b0;
			if (rx_go)
				ones <= RX_LINE ? ((ones == 3'h7) ? ones : ones + 3'h1) : 3'h0;
			if (rx_take)
			begin
				hist <= {hist[29:0], RX_LINE};
				rt <= (rt == `T_MAX) ? rt : rt + 6'h01;
				ph <= ph + 3'h1;
				if (rt >= `RX_HIST_OK)
					rcrc <= crc_step(rcrc, hist[6]);
				if (rt >= `RX_EMIT_T && ph == `RX_EMIT_PH)
				begin
					req_v <= 1'b1;
					req_st <= first;
					req_d <= {`TAG_DATA, rev8(hist[29:22])};
					first <= 1'b0;
				end
			end
			if (rx_abt)
			begin
				if (in_fr & ~first)
				begin
					req_v <= 1'b1;
					req_st <= 1'b0;
					req_d <= {`TAG_ABORT, 8'h00};
				end
				in_fr <= 1'b0;
			end
			if (rx_flag)
			begin
				if (in_fr & ~first)
				begin
					req_v <= 1'b1;
					req_st <= 1'b0;
					if (ph == `RX_END_PH && rt >= `RX_MIN_T && rcrc == `CRC_GOOD)
						req_d <= {`TAG_OK, 8'h00};
					else
						req_d <= {`TAG_BAD, 8'h00};
				end
				in_fr <= 1'b1;
				first <= 1'b1;
				rt <= 6'h00;
				ph <= 3'h0;
				rcrc <= `CRC_INIT;
			end
		end
	end

	// Overflow handling between the receive engine and its FIFO.
	reg rx_push;
	reg [9:0] rx_pdata;
	reg rx_ovf;
	reg next_drop;
	reg next_owe;
	always @*
	begin
		rx_push = 1'b0;
		rx_pdata = req_d;
		rx_ovf = 1'b0;
		next_drop = rx_drop;
		next_owe = rx_owe;
		if (req_v)
		begin
			if (rx_drop)
			begin
				if (req_st & rx_room & ~rx_owe)
				begin
					next_drop = 1'b0;
					rx_push = 1'b1;
				end
			end
			else if (rx_full)
			begin
				rx_ovf = 1'b1;
				next_drop = 1'b1;
				next_owe = ~req_st;
			end
			else
				rx_push = 1'b1;
		end
		else if (rx_owe & ~rx_full)
		begin
			rx_push = 1'b1;
			rx_pdata = {`TAG_ABORT, 8'h00};
			next_owe = 1'b0;
		end
	end

	wire [7:0] rx_set;
	assign rx_set = {rx_ovf, rx_invalid,
		req_v & (req_d[9:8] == `TAG_ABORT),
		req_v & (req_d[9:8] == `TAG_BAD),
		req_v & (req_d[9:8] == `TAG_OK),
		req_v & req_st, 2'b00};

	always @(posedge MCLK)
	begin
		if (RST)
		begin
			rx_wp <= 8'h00;
			rx_rp <= 8'h00;
			rx_cnt <= 9'h000;
			rx_drop <= 1'b0;
			rx_owe <= 1'b0;
		end
		else if (CE)
		begin
			rx_drop <= next_drop;
			rx_owe <= next_owe;
			if (rx_push)
			begin
				rx_mem[rx_wp] <= rx_pdata;
				rx_wp <= rx_wp + 8'h01;
			end
			if (rx_pop)
				rx_rp <= rx_rp + 8'h01;
			rx_cnt <= rx_cnt + {8'h00, rx_push} - {8'h00, rx_pop};
		end
	end

	// Transmit bit engine.
	reg [15:0] sh;
	reg [4:0] bcnt;
	reg [1:0] st;
	reg eop;
	reg [2:0] tones;
	reg [15:0] tcrc;
	wire stuff_now = (tones == `ONES_STUFF);
	wire tx_shift = tx_go & ~stuff_now;
	wire tx_load = tx_shift & (bcnt == 5'h01);
	wire tx_have = (tx_cnt != 9'h000);
	wire tx_want = tx_load & ((st == `ST_IDLE) | ((st == `ST_DATA) & ~eop & ~tx_abort_req));
	wire tx_pop = tx_want & tx_have;
	wire tx_under = tx_want & ~tx_have & (st == `ST_DATA);
	wire [15:0] tcrc_next = crc_step(tcrc, sh[0]);
	wire [8:0] tx_head = tx_mem[tx_rp];
	wire tx_sent = tx_load & (st == `ST_FCS);

	always @(posedge MCLK)
	begin
		if (RST)
		begin
			sh <= {8'h00, `FLAG_BYTE};
			bcnt <= `TX_BYTE_BITS;
			st <= `ST_IDLE;
			eop <= 1'b0;
			tones <= 3'h0;
			tcrc <= `CRC_INIT;
			TX_LINE <= 1'b1;
		end
		else if (tx_tick & ~tx_misc[`CTL_EN])
			TX_LINE <= 1'b1;
		else if (tx_go & stuff_now)
		begin
			TX_LINE <= 1'b0;
			tones <= 3'h0;
		end
		else if (tx_shift)
		begin
			TX_LINE <= sh[0];
			sh <= {1'b0, sh[15:1]};
			bcnt <= bcnt - 5'h01;
			tones <= (st != `ST_IDLE && sh[0]) ? tones + 3'h1 : 3'h0;
			if (st == `ST_DATA)
				tcrc <= tcrc_next;
			if (tx_load)
			begin
				bcnt <= `TX_BYTE_BITS;
				if (tx_pop)
				begin
					sh <= {8'h00, tx_head[7:0]};
					eop <= tx_head[8];
					st <= `ST_DATA;
					if (st == `ST_IDLE)
						tcrc <= `CRC_INIT;
				end
				else if (st == `ST_DATA & eop & ~tx_abort_req)
				begin
					sh <= ~tcrc_next;
					bcnt <= `TX_FCS_BITS;
					st <= `ST_FCS;
				end
				else if (st == `ST_DATA)
				begin
					sh <= {8'h00, `ABORT_BYTE};
					st <= `ST_IDLE;
				end
				else
				begin
					sh <= {8'h00, `FLAG_BYTE};
					st <= `ST_IDLE;
				end
			end
		end
	end

	always @(posedge MCLK)
	begin
		if (RST)
		begin
			tx_wp <= 8'h00;
			tx_rp <= 8'h00;
			tx_cnt <= 9'h000;
		end
		else if (CE)
		begin
			if (tx_push)
			begin
				tx_mem[tx_wp] <= {la == `ADR_TX_FD2, WDATA};
				tx_wp <= tx_wp + 8'h01;
			end
			if (tx_pop)
				tx_rp <= tx_rp + 8'h01;
			tx_cnt <= tx_cnt + {8'h00, tx_push} - {8'h00, tx_pop};
		end
	end

	wire [7:0] tx_set = {5'h00, tx_sent, tx_ovf, tx_under};
	wire [7:0] rx_clr = (wr & (la == `ADR_RX_LAT)) ? WDATA : 8'h00;
	wire [7:0] tx_clr = (wr & (la == `ADR_TX_LAT)) ? WDATA : 8'h00;
	wire [7:0] rx_rdclr = (rd & (la == `ADR_RX_LAT)) ? rx_lat : 8'h00;
	wire [7:0] tx_rdclr = (rd & (la == `ADR_TX_LAT)) ? tx_lat : 8'h00;
	wire [7:0] next_rx_pend = (rx_pend & ~rx_rdclr) | (rx_set & rx_ie);
	wire [7:0] next_tx_pend = (tx_pend & ~tx_rdclr) | (tx_set & tx_ie);

	// Configuration and latched status; a new event wins over a clear in the same cycle.
	always @(posedge MCLK)
	begin
		if (RST)
		begin
			rx_map <= 2'h0;
			tx_map <= 2'h0;
			rx_sup <= 8'h00;
			tx_sup <= 8'h00;
			rx_sel <= 32'h0000_0000;
			tx_sel <= 32'h0000_0000;
			rx_misc <= 8'h00;
			tx_misc <= 8'h00;
			rx_lvl <= 8'h00;
			tx_lvl <= 8'h00;
			rx_ie <= 8'h00;
			tx_ie <= 8'h00;
			rx_lat <= 8'h00;
			tx_lat <= 8'h00;
			rx_pend <= 8'h00;
			tx_pend <= 8'h00;
			tx_abort_req <= 1'b0;
			IRQ_N <= 1'b1;
		end
		else if (CE)
		begin
			rx_lat <= (rx_lat & ~rx_clr) | rx_set;
			tx_lat <= (tx_lat & ~tx_clr) | tx_set;
			rx_pend <= next_rx_pend;
			tx_pend <= next_tx_pend;
			IRQ_N <= ~(|{next_rx_pend, next_tx_pend});
			if (tx_load & (st == `ST_DATA))
				tx_abort_req <= 1'b0;
			if (wr)
			begin
				case (la)
					`ADR_RX_MAP: rx_map <= WDATA[1:0];
					`ADR_TX_MAP: tx_map <= WDATA[1:0];
					`ADR_RX_SUP: rx_sup <= WDATA;
					`ADR_TX_SUP: tx_sup <= WDATA;
					`ADR_RX_SEL1: rx_sel[7:0] <= WDATA;
					`ADR_RX_SEL2: rx_sel[15:8] <= WDATA;
					`ADR_RX_SEL3: rx_sel[23:16] <= WDATA;
					`ADR_RX_SEL4: rx_sel[31:24] <= WDATA;
					`ADR_TX_SEL1: tx_sel[7:0] <= WDATA;
					`ADR_TX_SEL2: tx_sel[15:8] <= WDATA;
					`ADR_TX_SEL3: tx_sel[23:16] <= WDATA;
					`ADR_TX_SEL4: tx_sel[31:24] <= WDATA;
					`ADR_RX_MISC: rx_misc <= WDATA;
					`ADR_RX_LVL: rx_lvl <= WDATA;
					`ADR_TX_LVL: tx_lvl <= WDATA;
					`ADR_RX_IE: rx_ie <= WDATA;
					`ADR_TX_IE: tx_ie <= WDATA;
					`ADR_TX_MISC:
					begin
						tx_misc <= WDATA & 8'hfd;
						if (WDATA[`CTL_ABORT])
							tx_abort_req <= 1'b1;
					end
					default: ;
				endcase
			end
		end
	end

	// Register reads: data appear in the cycle after the strobe only.
	reg [7:0] rmux;
	always @*
	begin
		case (la)
			`ADR_RX_MAP: rmux = {6'h00, rx_map};
			`ADR_TX_MAP: rmux = {6'h00, tx_map};
			`ADR_RX_SUP: rmux = rx_sup;
			`ADR_TX_SUP: rmux = tx_sup;
			`ADR_RX_SEL1: rmux = rx_sel[7:0];
			`ADR_RX_SEL2: rmux = rx_sel[15:8];
			`ADR_RX_SEL3: rmux = rx_sel[23:16];
			`ADR_RX_SEL4: rmux = rx_sel[31:24];
			`ADR_TX_SEL1: rmux = tx_sel[7:0];
			`ADR_TX_SEL2: rmux = tx_sel[15:8];
			`ADR_TX_SEL3: rmux = tx_sel[23:16];
			`ADR_TX_SEL4: rmux = tx_sel[31:24];
			`ADR_RX_MISC: rmux = rx_misc;
			`ADR_TX_MISC: rmux = tx_misc;
			`ADR_RX_LVL: rmux = rx_lvl;
			`ADR_TX_LVL: rmux = tx_lvl;
			`ADR_RX_IE: rmux = rx_ie;
			`ADR_TX_IE: rmux = tx_ie;
			`ADR_RX_LAT: rmux = rx_lat;
			`ADR_TX_LAT: rmux = tx_lat;
			`ADR_RX_RT: rmux = {4'h0, rx_drop, rx_full, rx_empty, {1'b0, rx_lvl} < rx_cnt};
			`ADR_TX_RT: rmux = {5'h00, tx_full, ~tx_have, tx_cnt < {1'b0, tx_lvl}};
			`ADR_TX_SPACE: rmux = tx_space;
			`ADR_RX_FD1: rmux = {rx_empty, 5'h00, rx_empty ? 2'h0 : rx_mem[rx_rp][9:8]};
			`ADR_RX_FD2: rmux = rx_empty ? 8'h00 : rx_mem[rx_rp][7:0];
			default: rmux = 8'h00;
		endcase
	end

	always @(posedge MCLK)
	begin
		if (RST)
			RDATA <= 8'h00;
		else if (CE)
			RDATA <= rd ? rmux : 8'h00;
	end
endmodule
`default_nettype wire

// ==== core/hdlc_regs.vh ====
// Register offsets, field positions, codes and counts for the HDLC packet controller.
// Assumes one framer copy per instance, selected by the FRAMER parameter of the top.
`ifndef HDLC_REGS_VH
`define HDLC_REGS_VH
`define FRAMER_SHIFT 9
`define ADR_RX_MAP 16'h008a
`define ADR_RX_SUP 16'h008d
`define ADR_RX_SEL1 16'h00dc
`define ADR_RX_SEL2 16'h00dd
`define ADR_RX_SEL3 16'h00de
`define ADR_RX_SEL4 16'h00df
`define ADR_TX_MAP 16'h018a
`define ADR_TX_SUP 16'h018d
`define ADR_TX_SEL1 16'h01dc
`define ADR_TX_SEL2 16'h01dd
`define ADR_TX_SEL3 16'h01de
`define ADR_TX_SEL4 16'h01df
`define ADR_TX_MISC 16'h1500
`define ADR_TX_LVL 16'h1501
`define ADR_TX_FD1 16'h1502
`define ADR_TX_FD2 16'h1503
`define ADR_TX_RT 16'h1504
`define ADR_TX_SPACE 16'h1505
`define ADR_TX_LAT 16'h1506
`define ADR_TX_IE 16'h1507
`define ADR_RX_MISC 16'h1510
`define ADR_RX_LVL 16'h1511
`define ADR_RX_RT 16'h1514
`define ADR_RX_LAT 16'h1515
`define ADR_RX_IE 16'h1516
`define ADR_RX_FD1 16'h151c
`define ADR_RX_FD2 16'h151d
`define MAP_SLOT 2'h1
`define MAP_SA 2'h2
`define MAP_FDL 2'h3
`define CTL_EN 0
`define CTL_ABORT 1
`define RL_OVF 7
`define RL_INVALID 6
`define RL_ABORT 5
`define RL_BAD 4
`define RL_END 3
`define RL_START 2
`define TL_UNDER 0
`define TL_OVF 1
`define TL_END 2
`define FIFO_DEPTH 9'h100
`define RX_ROOM 9'h010
`define TAG_DATA 2'h0
`define TAG_OK 2'h1
`define TAG_BAD 2'h2
`define TAG_ABORT 2'h3
`define CRC_INIT 16'hffff
`define CRC_POLY 16'h8408
`define CRC_GOOD 16'hf0b8
`define FLAG_BYTE 8'h7e
`define ABORT_BYTE 8'h7f
`define ONES_FLAG 3'h6
`define ONES_STUFF 3'h5
`define RX_HIST_OK 6'h07
`define RX_EMIT_T 6'h1e
`define RX_EMIT_PH 3'h6
`define RX_MIN_T 6'h27
`define RX_END_PH 3'h7
`define T_MAX 6'h3f
`define TX_BYTE_BITS 5'h08
`define TX_FCS_BITS 5'h10
`define ST_IDLE 2'h0
`define ST_DATA 2'h1
`define ST_FCS 2'h2
`endif

// ==== tb/hdlc_controller_sva.sv ====
// Checker on the HDLC controller top ports: bus answers, line timing, interrupt release.
// Assumes one framer copy chosen by FRAMER; the bench may pause the block through CE.
`timescale 1ns/1ns
`default_nettype none
`include "hdlc_regs.vh"
module hdlc_sva #(
	parameter [2:0] FRAMER = 3'h1
) (
	input wire MCLK,
	input wire RST,
	input wire CE,
	input wire [15:0] ADDR,
	input wire WR,
	input wire RD,
	input wire [7:0] RDATA,
	input wire LINE_TICK,
	input wire TX_LINE,
	input wire IRQ_N
);
	localparam [15:0] OFS = (FRAMER - 3'h1) << `FRAMER_SHIFT;
	wire lat_rd = RD && (ADDR == `ADR_RX_LAT + OFS || ADDR == `ADR_TX_LAT + OFS);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);
	// Three cycles with no latched-status read leave a pending interrupt in place.
	sequence s_no_rel;
		!lat_rd ##1 !IRQ_N && !lat_rd ##1 !lat_rd;
	endsequence
	a_rdata_idle: assert property (CE && !RD |=> RDATA == 8'h00)
		else $error("read data not zero outside a read answer");
	a_reset_state: assert property (disable iff (1'b0) RST |=> TX_LINE && IRQ_N)
		else $error("outputs not at rest after reset");
	a_tx_on_tick: assert property ($changed(TX_LINE) |->
		$past(LINE_TICK) || $past(WR) || $past(RST))
		else $error("line bit changed without a bit time");
	a_irq_release: assert property ($rose(IRQ_N) |-> $past(lat_rd))
		else $error("interrupt released without a status read");
	a_irq_hold: assert property (s_no_rel |=> !IRQ_N)
		else $error("interrupt dropped on its own");
	a_other_copy: assert property (FRAMER != 3'h1 && CE && RD &&
		ADDR == `ADR_TX_SPACE |=> RDATA == 8'h00)
		else $error("another framer copy answered");
	a_peek_form: assert property (CE && RD && ADDR == `ADR_RX_FD1 + OFS |=>
		RDATA[6:2] == 5'h00)
		else $error("peek carries stray bits");
	a_abort_read: assert property (CE && RD && ADDR == `ADR_TX_MISC + OFS |=> !RDATA[1])
		else $error("abort request reads back set");
endmodule
bind hdlc_controller hdlc_sva #(.FRAMER(FRAMER)) sva (.MCLK(MCLK), .RST(RST), .CE(CE),
	.ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA), .LINE_TICK(LINE_TICK),
	.TX_LINE(TX_LINE), .IRQ_N(IRQ_N));
`default_nettype wire

// ==== tb/framer_model.sv ====
// Framer stand-in: bit times with slot and bit position, transmit looped to receive.
// Assumes the same MCLK as the controller.
`timescale 1ns/1ns
`default_nettype none
module framer_model (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic TX_LINE,
	output logic LINE_TICK,
	output logic [4:0] SLOT,
	output logic [2:0] BITPOS,
	output logic SA_BIT,
	output logic [2:0] SA_NUM,
	output logic FDL_BIT,
	output logic RX_LINE
);
	initial {LINE_TICK, SLOT, BITPOS, RX_LINE} = 10'h001;
	// One bit time every two clocks, 32 slots of 8 bits a frame.
	always @(posedge MCLK)
	begin
		if (RST)
		begin
			LINE_TICK <= 1'b0;
			{SLOT, BITPOS} <= 8'h00;
		end
		else
		begin
			LINE_TICK <= !LINE_TICK;
			if (LINE_TICK)
				{SLOT, BITPOS} <= {SLOT, BITPOS} + 8'h01;
		end
		// Looped back, so the receiver hears each sent bit one used bit time later.
		RX_LINE <= TX_LINE;
	end
	assign SA_BIT = SLOT == 5'h00 && BITPOS >= 3'h3;
	assign SA_NUM = BITPOS - 3'h3;
	assign FDL_BIT = SLOT == 5'h00 && BITPOS == 3'h0;
endmodule
`default_nettype wire

// ==== tb/test_hdlc_controller.sv ====
// Self-checking bench for the HDLC controller as framer copy 2 on a looped line.
// Assumes the framer model and the checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
`include "hdlc_regs.vh"
module test_hdlc_controller;
	localparam [15:0] OFS = 16'h0200;
	logic mclk, rst, ce, wr, rd, tick, sa, fdl, rxl, txl, irq_n;
	logic [15:0] addr;
	logic [7:0] wdata, rdata, v;
	logic [4:0] slot;
	logic [2:0] bitpos, sanum;
	int failures = 0;
	int check_count = 0;
	hdlc_controller #(.FRAMER(3'h2)) DUT (.MCLK(mclk), .RST(rst), .CE(ce), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .LINE_TICK(tick), .SLOT(slot),
		.BITPOS(bitpos), .SA_BIT(sa), .SA_NUM(sanum), .FDL_BIT(fdl), .RX_LINE(rxl),
		.TX_LINE(txl), .IRQ_N(irq_n));
	framer_model fm (.MCLK(mclk), .RST(rst), .TX_LINE(txl), .LINE_TICK(tick), .SLOT(slot),
		.BITPOS(bitpos), .SA_BIT(sa), .SA_NUM(sanum), .FDL_BIT(fdl), .RX_LINE(rxl));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wrr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a + OFS;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rdr(input logic [15:0] a);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a + OFS;
		@(posedge mclk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic rc(input logic [15:0] a, input logic [7:0] e, input string n);
		rdr(a);
		chk(n, e, v);
	endtask
	task automatic poll(input logic [15:0] a, input logic [7:0] m, input int n);
		for (int i = 0; i < n; i++)
		begin
			rdr(a);
			if ((v & m) != 8'h00)
				break;
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic t_rst;
		rc(`ADR_RX_RT, 8'h02, "rx_rt");
		rc(`ADR_TX_RT, 8'h02, "tx_rt");
		rc(`ADR_TX_SPACE, 8'hff, "tx_space");
		rc(`ADR_TX_SPACE - OFS, 8'h00, "copy1");
		rc(16'h1508, 8'h00, "unmapped");
		chk("irq_n", 8'h01, {7'h00, irq_n});
		$display("t_rst done");
	endtask
	task automatic t_loop;
		// The receiver listens before the transmitter starts, so it hears the opening flag.
		wrr(`ADR_RX_MAP, 8'h01);
		wrr(`ADR_RX_SEL1, 8'hff);
		wrr(`ADR_RX_SUP, 8'h81);
		wrr(`ADR_RX_LVL, 8'h02);
		wrr(`ADR_RX_MISC, 8'h01);
		wrr(`ADR_TX_MAP, 8'h01);
		wrr(`ADR_TX_SEL1, 8'hff);
		wrr(`ADR_TX_SUP, 8'h81);
		wrr(`ADR_TX_MISC, 8'h01);
		wrr(`ADR_TX_FD1, 8'h11);
		wrr(`ADR_TX_FD1, 8'h7e);
		wrr(`ADR_TX_FD2, 8'hff);
		poll(`ADR_RX_LAT, 8'h08, 3000);
		rc(`ADR_RX_RT, 8'h01, "rx_rt4");
		rc(`ADR_RX_FD1, 8'h00, "peek0");
		rc(`ADR_RX_FD2, 8'h11, "b0");
		rc(`ADR_RX_FD2, 8'h7e, "b1");
		rc(`ADR_RX_RT, 8'h00, "rx_rt2");
		rc(`ADR_RX_FD2, 8'hff, "b2");
		rc(`ADR_RX_FD1, 8'h01, "end_good");
		rc(`ADR_RX_FD2, 8'h00, "tag_pop");
		rc(`ADR_RX_FD1, 8'h80, "peek_empty");
		rc(`ADR_RX_LAT, 8'h0c, "rx_lat");
		rc(`ADR_TX_LAT, 8'h04, "tx_lat");
		wrr(`ADR_RX_LAT, 8'h04);
		rc(`ADR_RX_LAT, 8'h08, "clr_one");
		wrr(`ADR_RX_LAT, 8'h08);
		rc(`ADR_RX_LAT, 8'h00, "clr_all");
		rc(`ADR_RX_RT, 8'h02, "rt_kept");
		$display("t_loop done");
	endtask
	task automatic t_irq;
		rc(`ADR_RX_FD2, 8'h00, "empty_rd");
		rc(`ADR_RX_RT, 8'h02, "no_pop");
		rc(`ADR_RX_LAT, 8'h40, "invalid");
		wrr(`ADR_RX_LAT, 8'h40);
		wrr(`ADR_RX_IE, 8'h40);
		rc(`ADR_RX_FD2, 8'h00, "empty_rd2");
		repeat (3) @(posedge mclk);
		#1 chk("irq_low", 8'h00, {7'h00, irq_n});
		rc(`ADR_RX_LAT, 8'h40, "irq_src");
		repeat (2) @(posedge mclk);
		#1 chk("irq_high", 8'h01, {7'h00, irq_n});
		$display("t_irq done");
	endtask
	task automatic t_fill;
		wrr(`ADR_RX_MISC, 8'h00);
		wrr(`ADR_TX_MISC, 8'h00);
		// A write while the clock enable is low must leave the transmit FIFO untouched.
		@(posedge mclk);
		ce <= 1'b0;
		wrr(`ADR_TX_FD1, 8'h55);
		ce <= 1'b1;
		rc(`ADR_TX_SPACE, 8'hff, "ce_frozen");
		wrr(`ADR_TX_LVL, 8'h10);
		wrr(`ADR_TX_LAT, 8'hff);
		for (int i = 0; i < 15; i++)
			wrr(`ADR_TX_FD1, 8'(i));
		rc(`ADR_TX_RT, 8'h01, "below_lvl");
		wrr(`ADR_TX_FD1, 8'h0f);
		rc(`ADR_TX_RT, 8'h00, "at_lvl");
		rc(`ADR_TX_SPACE, 8'hf0, "space16");
		for (int i = 0; i < 240; i++)
			wrr(`ADR_TX_FD1, 8'(i));
		rc(`ADR_TX_SPACE, 8'h00, "space_full");
		rc(`ADR_TX_RT, 8'h04, "tx_full");
		wrr(`ADR_TX_FD1, 8'haa);
		rc(`ADR_TX_LAT, 8'h02, "tx_ovf");
		rc(`ADR_TX_SPACE, 8'h00, "ovf_drop");
		$display("t_fill done");
	endtask
	task automatic t_under;
		wrr(`ADR_TX_MISC, 8'h01);
		poll(`ADR_TX_LAT, 8'h01, 20000);
		chk("tx_under", 8'h01, v & 8'h01);
		rc(`ADR_TX_RT, 8'h03, "tx_empty");
		wrr(`ADR_TX_MISC, 8'h03);
		rc(`ADR_TX_MISC, 8'h01, "abort_rd");
		$display("t_under done");
	endtask
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial
	begin
		#600000;
		failures++;
		end_sim;
	end
	initial
	begin
		{rst, ce, wr, rd, addr, wdata} = 28'hc00_0000;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		t_rst;
		t_loop;
		t_irq;
		t_fill;
		t_under;
		end_sim;
	end
endmodule
`default_nettype wire
